// file: assf_pkg.sv
// Package: constants and types of the sequence status and test-control block
// Functional notes
// (R1) Sequence end sets done flag, each scan
// (R2) Done flag cleared: write one, start, fast read
// (R3) Edge trigger during sequence sets trigger overrun
// (R4) Trigger overrun cleared: one, config write, start
// (R5) Result write over set complete flag: overrun
// (R6) Result overrun cleared: one, sequence start
// (R7) Four-bit counter names destination result slot
// (R8) Non-FIFO: counter zeroed at sequence start/end
// (R9) FIFO: counter continues across sequences
// (R10) Counter wraps from fifteen to zero
// (R11) Any control register write clears counter
// (R12) Counter bits ignore writes; status always readable
// (R13) Reserved test register: unpredictable, special-mode writes
// (R14) Special test register bits 7:6 unpredictable
// (R15) Special enable remaps low select code bits
// (R16) Codes 0100/0101/0110: high, low, midpoint reference
// (R17) Continuous bit repeats sequences, else single
// (R18) Start write clears all complete flags
// (R19) Writing zero to a flag changes nothing
// (R20) Level trigger never sets trigger overrun
package assf_pkg;
    // ------------------------------------------------------------
    // Register map (byte offsets, chosen locally)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTL0 = 4'h0;
    localparam logic [3:0] ADDR_CTL4 = 4'h4;
    localparam logic [3:0] ADDR_CTL5 = 4'h5;
    localparam logic [3:0] ADDR_STAT = 4'h6;
    localparam logic [3:0] ADDR_TEST0 = 4'h8;
    localparam logic [3:0] ADDR_TEST1 = 4'h9;
    localparam logic [3:0] ADDR_MODE = 4'ha;
    localparam logic [3:0] ADDR_RESULT = 4'hb;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DONE = 7;
    localparam int BIT_TRIG_OVR = 5;
    localparam int BIT_RES_OVR = 4;
    localparam int BIT_SPECIAL_EN = 0;
    localparam int BIT_MODE_FIFO = 0;
    localparam int BIT_MODE_CONT = 1;
    localparam int BIT_MODE_FAST = 2;
    localparam int BIT_MODE_LEVEL = 3;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TEST = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [3:0] RST_CNT = 4'h0;
    localparam logic [15:0] RST_CPL = 16'h0000;
    // Value returned for unpredictable bits 7:6 of the special test register (arbitrary)
    localparam logic [7:0] UNPRED_VAL = 8'h00;

    typedef enum logic [2:0] {
        CH_NORMAL = 3'b001,
        CH_SPECIAL = 3'b010,
        CH_RESERVED = 3'b100
    } assf_chkind_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_RUN = 2'b10
    } assf_seq_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } assf_bus_t;

    typedef struct packed {
        logic conv_done;
        logic seq_last;
        logic ext_start;
        logic trig_edge;
    } assf_evt_t;
endpackage : assf_pkg

// file: assf_top.sv
// Module: sequence status flags, result slot counter and test registers
`timescale 1ns/1ps
module assf_top (
    input wire logic I_MCLK, // 125 MHz clock
    input wire logic I_RST_N, // Async reset, active low
    input wire logic [3:0] I_ADDR, // Register address
    input wire logic [7:0] I_WDATA, // Write data
    input wire logic I_WR, // Write strobe
    input wire logic I_RD, // Read strobe
    input wire logic I_SPECIAL_MODE, // Special operating mode
    input wire logic I_CONV_DONE, // Conversion result written
    input wire logic I_SEQ_LAST, // With conv_done: last of sequence
    input wire logic I_EXT_START, // External trigger started sequence
    input wire logic I_TRIG_EDGE, // Active external trigger edge
    input wire logic [3:0] I_CHAN_SEL, // Channel select code
    output logic [7:0] O_RDATA, // Read data, cycle after strobe
    output logic [3:0] O_SLOT, // Result slot counter
    output logic [15:0] O_CPL, // Conversion complete flags
    output logic O_SEQ_ACTIVE, // Sequence running
    output logic O_ABORT, // Sequence aborted by config write
    output logic [3:0] O_CONV_CHAN, // Channel or special code
    output logic O_CONV_SPECIAL, // Special internal channel chosen
    output logic O_CONV_RESERVED // Reserved special code
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_m_q;
    logic rst_n_q;
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    // Special mode pin comes from outside: two flops
    // Two cycles of lag are harmless: the mode pin is quasi-static
    logic spm_m_q;
    logic spm_q;
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            spm_m_q <= 1'b0;
            spm_q <= 1'b0;
        end else begin
            spm_m_q <= I_SPECIAL_MODE;
            spm_q <= spm_m_q;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assf_pkg::assf_bus_t bus;
    assf_pkg::assf_evt_t evt;
    assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
    assign evt = '{conv_done: I_CONV_DONE, seq_last: I_SEQ_LAST, ext_start: I_EXT_START,
                   trig_edge: I_TRIG_EDGE};

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    logic wr_start;
    logic wr_cfg;
    logic wr_stat;
    logic rd_result;
    logic seq_start;
    logic seq_end;
    logic [7:0] mode_q;
    assign wr_start = bus.wr && hit(bus.addr, assf_pkg::ADDR_CTL5);
    assign wr_cfg = bus.wr && (bus.addr <= assf_pkg::ADDR_CTL4);
    assign wr_stat = bus.wr && hit(bus.addr, assf_pkg::ADDR_STAT);
    assign rd_result = bus.rd && hit(bus.addr, assf_pkg::ADDR_RESULT);
    assign seq_start = wr_start || evt.ext_start;
    assign seq_end = evt.conv_done && evt.seq_last;

    logic fifo_mode;
    logic cont_mode;
    logic fast_clr;
    logic level_trig;
    assign fifo_mode = mode_q[assf_pkg::BIT_MODE_FIFO];
    assign cont_mode = mode_q[assf_pkg::BIT_MODE_CONT];
    assign fast_clr = mode_q[assf_pkg::BIT_MODE_FAST];
    assign level_trig = mode_q[assf_pkg::BIT_MODE_LEVEL];

    // ------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------
    assf_pkg::assf_seq_t seq_q;
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            seq_q <= assf_pkg::SEQ_IDLE;
        end else begin
            case (seq_q)
                assf_pkg::SEQ_IDLE: begin
                    if (seq_start) begin
                        seq_q <= assf_pkg::SEQ_RUN;
                    end
                end
                assf_pkg::SEQ_RUN: begin
                    // Abort wins over an ending or restarting sequence
                    if (wr_cfg) begin
                        seq_q <= assf_pkg::SEQ_IDLE;
                    // (R17) continuous keeps running
                    end else if (seq_end && !cont_mode && !seq_start) begin
                        seq_q <= assf_pkg::SEQ_IDLE;
                    end
                end
                default: seq_q <= assf_pkg::SEQ_IDLE;
            endcase
        end
    end
    assign O_SEQ_ACTIVE = (seq_q == assf_pkg::SEQ_RUN);
    assign O_ABORT = wr_cfg;

    // ------------------------------------------------------------
    // Mode and test registers
    // ------------------------------------------------------------
    logic [7:0] test0_q;
    logic [7:0] test1_q;
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= assf_pkg::RST_MODE;
            test0_q <= assf_pkg::RST_TEST;
            test1_q <= assf_pkg::RST_TEST;
        end else begin
            if (bus.wr && hit(bus.addr, assf_pkg::ADDR_MODE)) begin
                mode_q <= bus.wdata;
            end
            // (R13) writable only in special mode
            if (bus.wr && hit(bus.addr, assf_pkg::ADDR_TEST0) && spm_q) begin
                test0_q <= bus.wdata;
            end
            // (R14) writable any time
            if (bus.wr && hit(bus.addr, assf_pkg::ADDR_TEST1)) begin
                test1_q <= bus.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Result slot counter
    // ------------------------------------------------------------
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (evt.conv_done) begin
            // (R10) natural wrap at fifteen
            cnt_d = cnt_q + 4'h1;
        end
        // (R8) zero at start and end without FIFO
        if (!fifo_mode && (seq_end || evt.ext_start)) begin
            cnt_d = assf_pkg::RST_CNT;
        end
        // Clears come last so they outrank an increment
        // (R11) any control write clears, FIFO too
        if (wr_cfg || wr_start) begin
            cnt_d = assf_pkg::RST_CNT;
        end
    end
    // (R9) FIFO mode leaves counter running
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q <= assf_pkg::RST_CNT;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // (R7) counter points at destination slot
    assign O_SLOT = cnt_q;

    // ------------------------------------------------------------
    // Conversion complete flags
    // ------------------------------------------------------------
    // Clearing by result reads belongs to the result path, not here
    logic [15:0] cpl_q;
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cpl_q <= assf_pkg::RST_CPL;
        end else begin
            // (R18) start write clears all, overriding set
            if (wr_start) begin
                cpl_q <= assf_pkg::RST_CPL;
            end else if (evt.conv_done) begin
                cpl_q[cnt_q] <= 1'b1;
            end
        end
    end
    assign O_CPL = cpl_q;

    // ------------------------------------------------------------
    // Status flags; set wins over clear except config write for trigger overrun and start write for result overrun
    // ------------------------------------------------------------
    logic done_q;
    logic tovr_q;
    logic rovr_q;
    logic w1_done;
    logic w1_tovr;
    logic w1_rovr;
    // (R19) only a written one clears
    assign w1_done = wr_stat && bus.wdata[assf_pkg::BIT_DONE];
    assign w1_tovr = wr_stat && bus.wdata[assf_pkg::BIT_TRIG_OVR];
    assign w1_rovr = wr_stat && bus.wdata[assf_pkg::BIT_RES_OVR];

    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            done_q <= 1'b0;
        end else begin
            // (R1) set on every sequence end while running
            if (seq_end && O_SEQ_ACTIVE) begin
                done_q <= 1'b1;
            // (R2) three clearing causes
            end else if (w1_done || wr_start || (rd_result && fast_clr)) begin
                done_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tovr_q <= 1'b0;
        end else begin
            // Abort outranks an edge: the sequence is gone
            // (R3) edge during running sequence; (R20) not in level mode
            if (evt.trig_edge && O_SEQ_ACTIVE && !level_trig && !wr_cfg) begin
                tovr_q <= 1'b1;
            // (R4) one, config or start write clears
            end else if (w1_tovr || wr_cfg || wr_start) begin
                tovr_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rovr_q <= 1'b0;
        end else begin
            // Start write empties the flags this test looks at
            // (R5) overwrite of unread result
            if (evt.conv_done && cpl_q[cnt_q] && !wr_start) begin
                rovr_q <= 1'b1;
            // (R6) one or new sequence clears
            end else if (w1_rovr || seq_start) begin
                rovr_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Channel decode
    // ------------------------------------------------------------
    function automatic assf_pkg::assf_chkind_t ch_kind(input logic spec_en, input logic [3:0] code);
        if (!spec_en) begin
            ch_kind = assf_pkg::CH_NORMAL;
        end else if (code == 4'h4 || code == 4'h5 || code == 4'h6) begin
            ch_kind = assf_pkg::CH_SPECIAL;
        end else if (code[3]) begin
            ch_kind = assf_pkg::CH_NORMAL;
        end else begin
            ch_kind = assf_pkg::CH_RESERVED;
        end
    endfunction : ch_kind

    assf_pkg::assf_chkind_t kind;
    // (R15) special enable remaps code; (R16) reference codes
    assign kind = ch_kind(test1_q[assf_pkg::BIT_SPECIAL_EN], I_CHAN_SEL);
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            O_CONV_CHAN <= 4'h0;
            O_CONV_SPECIAL <= 1'b0;
            O_CONV_RESERVED <= 1'b0;
        end else begin
            O_CONV_CHAN <= I_CHAN_SEL;
            O_CONV_SPECIAL <= (kind == assf_pkg::CH_SPECIAL);
            O_CONV_RESERVED <= (kind == assf_pkg::CH_RESERVED);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            O_RDATA <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                // (R12) status readable any time
                assf_pkg::ADDR_STAT: O_RDATA <= {done_q, 1'b0, tovr_q, rovr_q, cnt_q};
                // Undefined read value: show the stored byte so it stays observable
                assf_pkg::ADDR_TEST0: O_RDATA <= test0_q;
                assf_pkg::ADDR_TEST1: O_RDATA <= {assf_pkg::UNPRED_VAL[7:6], test1_q[5:0]};
                assf_pkg::ADDR_MODE: O_RDATA <= mode_q;
                default: O_RDATA <= 8'h00;
            endcase
        end else begin
            O_RDATA <= 8'h00;
        end
    end
endmodule : assf_top

// file: assf_assertions.sv
// Checker: timing relations on the sequence status block ports
`timescale 1ns/1ps
module assf_checker (
    input wire logic I_MCLK, // Clock
    input wire logic I_RST_N, // Reset, low
    input wire logic [3:0] I_ADDR, // Address
    input wire logic [7:0] I_WDATA, // Write data
    input wire logic I_WR, // Write strobe
    input wire logic I_RD, // Read strobe
    input wire logic I_CONV_DONE, // Result written
    input wire logic I_SEQ_LAST, // Last of sequence
    input wire logic I_EXT_START, // Trigger start
    input wire logic I_TRIG_EDGE, // Trigger edge
    input wire logic [3:0] I_CHAN_SEL, // Select code
    input wire logic [7:0] O_RDATA, // Read data
    input wire logic [3:0] O_SLOT, // Slot counter
    input wire logic [15:0] O_CPL, // Complete flags
    input wire logic O_SEQ_ACTIVE, // Running
    input wire logic [3:0] O_CONV_CHAN, // Channel copy
    input wire logic O_CONV_SPECIAL, // Special decode
    input wire logic O_CONV_RESERVED, // Reserved decode
    input wire logic O_ABORT // Abort pulse
);
    localparam logic [3:0] ST = assf_pkg::ADDR_STAT;
    localparam logic [3:0] C4 = assf_pkg::ADDR_CTL4;
    localparam logic [3:0] C5 = assf_pkg::ADDR_CTL5;
    // ------------------------------------------------------------
    // Shadow state
    // ------------------------------------------------------------
    // Outputs lag release while the internal reset copy settles
    logic [1:0] live_q;
    logic spen_q;
    logic level_q;
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            live_q <= 2'h0;
            spen_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            if (live_q != 2'h3) begin
                live_q <= live_q + 2'h1;
            end
            if (I_WR && I_ADDR == assf_pkg::ADDR_TEST1) begin
                spen_q <= I_WDATA[assf_pkg::BIT_SPECIAL_EN];
            end
            if (I_WR && I_ADDR == assf_pkg::ADDR_MODE) begin
                level_q <= I_WDATA[assf_pkg::BIT_MODE_LEVEL];
            end
        end
    end
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    start_done_a: assert property (
        (I_WR && I_ADDR == C5 && !I_CONV_DONE) ##1 (I_RD && I_ADDR == ST) |=> !O_RDATA[7])
        else $error("done flag set after start write");
    cfg_trig_a: assert property (
        (I_WR && I_ADDR <= C4) ##1 (I_RD && I_ADDR == ST) |=> !O_RDATA[5])
        else $error("trigger overrun kept after config write");
    trig_set_a: assert property (
        (I_TRIG_EDGE && O_SEQ_ACTIVE && !level_q && !I_WR) ##1 (I_RD && I_ADDR == ST) |=> O_RDATA[5])
        else $error("trigger overrun not set");
    slot_abort_a: assert property (
        I_WR && I_ADDR <= C5 && !I_CONV_DONE |=> O_SLOT == 4'h0)
        else $error("slot not cleared by control write");
    slot_step_a: assert property (
        I_CONV_DONE && !I_SEQ_LAST && !I_WR && !I_EXT_START |=> O_SLOT == $past(O_SLOT) + 4'h1)
        else $error("slot did not advance by one");
    slot_hold_a: assert property (
        I_WR && I_ADDR == ST && !I_CONV_DONE && !I_EXT_START |=> $stable(O_SLOT))
        else $error("slot changed by status write");
    cpl_set_a: assert property (
        I_CONV_DONE && !I_WR |=> O_CPL[$past(O_SLOT)])
        else $error("complete flag of slot not set");
    cpl_start_a: assert property (
        I_WR && I_ADDR == C5 |=> O_CPL == 16'h0000)
        else $error("complete flags kept after start");
    chan_copy_a: assert property (
        live_q == 2'h3 |=> O_CONV_CHAN == $past(I_CHAN_SEL))
        else $error("channel copy wrong");
    special_dec_a: assert property (
        live_q == 2'h3 && !(I_WR && I_ADDR == assf_pkg::ADDR_TEST1)
        |=> O_CONV_SPECIAL == ($past(spen_q) && ($past(I_CHAN_SEL) inside {4'h4, 4'h5, 4'h6})))
        else $error("special channel decode wrong");
    reserved_dec_a: assert property (
        live_q == 2'h3 && !(I_WR && I_ADDR == assf_pkg::ADDR_TEST1)
        |=> O_CONV_RESERVED == ($past(spen_q) && ($past(I_CHAN_SEL) inside {[4'h0:4'h3], 4'h7})))
        else $error("reserved channel decode wrong");
    abort_pulse_a: assert property (
        O_ABORT == (I_WR && I_ADDR <= C4))
        else $error("abort pulse wrong");
    abort_idle_a: assert property (
        I_WR && I_ADDR <= C4 |=> !O_SEQ_ACTIVE)
        else $error("sequence kept running after abort");
    start_run_a: assert property (
        I_WR && I_ADDR == C5 |=> O_SEQ_ACTIVE)
        else $error("sequence not running after start");
    seq_end_c: cover property (I_CONV_DONE && I_SEQ_LAST);
    trig_run_c: cover property (I_TRIG_EDGE && O_SEQ_ACTIVE);
    special_c: cover property (O_CONV_SPECIAL);
endmodule : assf_checker

bind assf_top assf_checker chk_i (.I_MCLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_CONV_DONE,
    .I_SEQ_LAST, .I_EXT_START, .I_TRIG_EDGE, .I_CHAN_SEL, .O_RDATA, .O_SLOT, .O_CPL, .O_SEQ_ACTIVE,
    .O_CONV_CHAN, .O_CONV_SPECIAL, .O_CONV_RESERVED, .O_ABORT);

// file: test_adc_sequence_status_flags.sv
// Testbench: register and event stimulus for the sequence status block
`timescale 1ns/1ps
module test_adc_sequence_status_flags;
    localparam logic [3:0] ST = assf_pkg::ADDR_STAT;
    localparam logic [3:0] C0 = assf_pkg::ADDR_CTL0;
    localparam logic [3:0] C4 = assf_pkg::ADDR_CTL4;
    localparam logic [3:0] C5 = assf_pkg::ADDR_CTL5;
    localparam logic [3:0] T1 = assf_pkg::ADDR_TEST1;
    localparam logic [3:0] MD = assf_pkg::ADDR_MODE;
    // Event bits: done, last, external start, trigger edge
    localparam logic [3:0] DN = 4'h8;
    localparam logic [3:0] CL = 4'hc;
    localparam logic [3:0] ES = 4'h2;
    localparam logic [3:0] TE = 4'h1;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, spec = 1'b0, rd_q = 1'b0;
    logic cdone = 1'b0, last = 1'b0, estart = 1'b0, tedge = 1'b0;
    logic [3:0] addr = 4'h0, chsel = 4'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [15:0] cpl, note;
    logic spec_lvl = 1'b0;
    logic [15:0] notes[$];
    int seed = 97;
    int fails = 0;
    int total_checks = 0;

    always #4 clk = ~clk;

    assf_top assf_top_i (.I_MCLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .I_SPECIAL_MODE(spec), .I_CONV_DONE(cdone), .I_SEQ_LAST(last), .I_EXT_START(estart),
        .I_TRIG_EDGE(tedge), .I_CHAN_SEL(chsel), .O_RDATA(rdata), .O_SLOT(), .O_CPL(cpl),
        .O_SEQ_ACTIVE(), .O_ABORT(), .O_CONV_CHAN(), .O_CONV_SPECIAL(), .O_CONV_RESERVED());

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    // Every input but clock and reset is driven once per edge, so back-to-back calls never race
    task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d, input logic [3:0] e);
        logic [31:0] rnd;
        rnd = $random(seed);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        {cdone, last, estart, tedge} <= e;
        chsel <= rnd[3:0];
        spec <= spec_lvl;
    endtask : cyc

    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        cyc(1'b1, 1'b0, a, d, 4'h0);
    endtask : wrr

    // Mask selects the bits whose value is compared
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        notes.push_back({m, e});
        cyc(1'b0, 1'b1, a, 8'h00, 4'h0);
    endtask : rdc

    task automatic ev(input logic [3:0] e, input int n);
        repeat (n) cyc(1'b0, 1'b0, ST, 8'h00, e);
    endtask : ev

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Read monitor
    // ------------------------------------------------------------
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) begin
        if (rd_q) begin
            note = (notes.size() > 0) ? notes.pop_front() : 16'hff5a;
            check({8'h00, rdata & note[15:8]}, {8'h00, note[7:0]});
        end
    end

    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        ev(4'h0, 3);
        rdc(ST, 8'hff, 8'h00);
        rdc(4'h7, 8'hff, 8'h00);
        wrr(assf_pkg::ADDR_TEST0, 8'h5a);
        rdc(assf_pkg::ADDR_TEST0, 8'hff, 8'h00);
        // Special mode reaches the block two cycles late
        spec_lvl = 1'b1;
        ev(4'h0, 3);
        wrr(assf_pkg::ADDR_TEST0, 8'h5a);
        rdc(assf_pkg::ADDR_TEST0, 8'hff, 8'h5a);
        spec_lvl = 1'b0;
        wrr(T1, 8'hff);
        rdc(T1, 8'hc1, 8'h01);
        // Single sequence, counter back to zero at its end
        wrr(C5, 8'h00);
        ev(DN, 2);
        rdc(ST, 8'hff, 8'h02);
        ev(CL, 1);
        rdc(ST, 8'hff, 8'h80);
        @(negedge clk);
        check(cpl, 16'h0007);
        wrr(ST, 8'h00);
        rdc(ST, 8'hff, 8'h80);
        wrr(ST, 8'h80);
        rdc(ST, 8'hff, 8'h00);
        // Continuous scan: overwrite slot 0 and a trigger edge mid-run
        wrr(MD, 8'h02);
        wrr(C5, 8'h00);
        ev(DN, 1);
        ev(CL, 1);
        ev(DN, 1);
        ev(TE, 1);
        rdc(ST, 8'hff, 8'hb1);
        wrr(C0, 8'h00);
        rdc(ST, 8'hff, 8'h90);
        wrr(ST, 8'h10);
        rdc(ST, 8'hff, 8'h80);
        wrr(C5, 8'h00);
        rdc(ST, 8'hff, 8'h00);
        @(negedge clk);
        check(cpl, 16'h0000);
        // Level trigger first, then edge trigger
        wrr(MD, 8'h08);
        wrr(C5, 8'h00);
        ev(TE, 1);
        rdc(ST, 8'hff, 8'h00);
        wrr(MD, 8'h00);
        ev(TE, 1);
        rdc(ST, 8'hff, 8'h20);
        wrr(C5, 8'h00);
        rdc(ST, 8'hff, 8'h00);
        // Fast clear by a result read
        wrr(MD, 8'h04);
        wrr(C5, 8'h00);
        ev(CL, 1);
        rdc(ST, 8'hff, 8'h80);
        rdc(assf_pkg::ADDR_RESULT, 8'hff, 8'h00);
        rdc(ST, 8'hff, 8'h00);
        // FIFO: counter runs on across sequences and wraps
        wrr(MD, 8'h01);
        wrr(C5, 8'h00);
        ev(DN, 2);
        ev(CL, 1);
        rdc(ST, 8'hff, 8'h83);
        wrr(ST, 8'h0f);
        rdc(ST, 8'hff, 8'h83);
        ev(ES, 1);
        ev(DN, 12);
        ev(CL, 1);
        rdc(ST, 8'hff, 8'h80);
        ev(ES, 1);
        ev(DN, 2);
        rdc(ST, 8'hff, 8'h92);
        wrr(C4, 8'h00);
        rdc(ST, 8'hff, 8'h90);
        ev(ES, 1);
        rdc(ST, 8'hff, 8'h80);
        wrr(C0, 8'h00);
        // Without FIFO an external start zeroes the counter
        wrr(MD, 8'h00);
        ev(DN, 1);
        rdc(ST, 8'hff, 8'h91);
        ev(ES, 1);
        rdc(ST, 8'hff, 8'h80);
        wrr(T1, 8'h00);
        rdc(T1, 8'hc1, 8'h00);
        ev(4'h0, 20);
        if (notes.size() != 0) begin
            fails++;
        end
        summarize();
    end
endmodule : test_adc_sequence_status_flags
